// File: core/ssw_supervisor.sv
// Supply supervisor: stretched reset, watchdog and power-fail flag.
// Overview of operation
// - Manual reset input driven low starts a reset pulse.
// - Any triggered reset holds the low reset output for nominally 200 ms.
// - Reset output stays low while supply is below threshold.
// - After supply recovery or manual release, reset stays low 200 ms more.
// - Reset stretch lies between 140 ms and 280 ms, typically 200 ms.
// - Watchdog expiry never asserts reset by itself.
// - Kick input held at one level for 1.6 s expires the watchdog.
// - Watchdog period from last clear lies between 1.00 s and 2.25 s.
// - Timer clears during reset, while kick floats, and on kick edges.
// - Floating kick input disables the watchdog entirely.
// - Expired output stays low until the timer is next cleared.
// - Expired output low during low supply, high at once on recovery.
// - Kick pulses count only once two filter samples agree; the host keeps them three clocks.
// - Power-fail flag low while monitored voltage is below reference.
// - Active-high reset is always the exact complement of the low one.
// - A dip during a running pulse extends it at least 140 ms more.
// - Timer counts once reset is released and kick is driven.
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int unsigned TB_CYCLES = TICK_CYCLES,
  parameter int unsigned RST_TICKS = PULSE_TICKS,
  parameter int unsigned WDT_TICKS = WD_TICKS
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic rst,
  // Supply and comparator sense, asynchronous.
  input  wire logic supply_low_in,
  input  wire logic powerfail_sense_in,
  // Manual reset line, asynchronous, active low.
  input  wire logic manual_reset_n,
  // Watchdog kick pin and its undriven indication from the pad.
  input  wire logic watchdog_kick_in,
  input  wire logic watchdog_kick_hiz,
  // Outputs toward the host processor.
  output wire logic system_reset_n,
  output wire logic system_reset,
  output wire logic watchdog_expired_n,
  output wire logic powerfail_flag_n
);

  localparam int unsigned PW = (TB_CYCLES > 1) ? $clog2(TB_CYCLES) : 1;
  localparam int unsigned SW = $clog2(RST_TICKS + 1);
  localparam int unsigned WW = $clog2(WDT_TICKS + 1);

  typedef struct packed {
    ssw_rst_state_t rst_state;
    logic [SW-1:0]  stretch_cnt;
    logic [PW-1:0]  pre_cnt;
    logic           tick;
    logic [WW-1:0]  wd_cnt;
    logic           wd_exp;
    logic           kick_prev;
    logic           rst_n;
    logic           wdo_n;
    logic           pfo_n;
  } ssw_state_t;

  ssw_state_t st_r;
  ssw_state_t st_nxt;

  ssw_pin_if #(.W(PIN_COUNT)) pins ();

  logic mr_low;
  logic sup_low;
  logic kick_lvl;
  logic kick_hiz;
  logic pf_ok;
  logic hold_req;
  logic kick_edge;
  logic wd_clear;

  // Every pin is asynchronous to clk_sys and goes through the filter.
  assign pins.raw[PIN_MR]    = manual_reset_n;
  assign pins.raw[PIN_SUPLO] = supply_low_in;
  assign pins.raw[PIN_PF]    = powerfail_sense_in;
  assign pins.raw[PIN_KICK]  = watchdog_kick_in;
  assign pins.raw[PIN_HIZ]   = watchdog_kick_hiz;

  ssw_pin_filter #(
    .W       (PIN_COUNT),
    .RST_VAL (PIN_RESET)
  ) u_filter (
    .clk_sys (clk_sys),
    .rst     (rst),
    .pins    (pins)
  );

  // Filtered levels and the events derived from them.
  assign mr_low    = ~pins.clean[PIN_MR];
  assign sup_low   = pins.clean[PIN_SUPLO];
  assign pf_ok     = pins.clean[PIN_PF];
  assign kick_lvl  = pins.clean[PIN_KICK];
  assign kick_hiz  = pins.clean[PIN_HIZ];
  assign hold_req  = mr_low | sup_low;
  assign kick_edge = kick_lvl ^ st_r.kick_prev;
  assign wd_clear  = ~st_r.rst_n | kick_hiz | kick_edge;

  // Next-state logic for timebase, reset sequencer and watchdog.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;

    if (st_r.pre_cnt == PW'(TB_CYCLES - 1)) begin
      st_nxt.pre_cnt = '0;
      st_nxt.tick    = 1'b1;
    end else begin
      st_nxt.pre_cnt = st_r.pre_cnt + 1'b1;
    end

    unique case (st_r.rst_state)
      RST_HOLD: begin
        if (!hold_req) begin
          st_nxt.rst_state   = RST_STRETCH;
          st_nxt.stretch_cnt = '0;
        end
      end
      RST_STRETCH: begin
        if (hold_req) begin
          st_nxt.rst_state = RST_HOLD;
        end else if (st_r.tick) begin
          if (st_r.stretch_cnt == SW'(RST_TICKS - 1)) begin
            st_nxt.rst_state = RST_RUN;
          end else begin
            st_nxt.stretch_cnt = st_r.stretch_cnt + 1'b1;
          end
        end
      end
      RST_RUN: begin
        if (hold_req) begin
          st_nxt.rst_state = RST_HOLD;
        end
      end
    endcase
    st_nxt.rst_n = (st_nxt.rst_state == RST_RUN);

    st_nxt.kick_prev = kick_lvl;
    // expired flag held until a clear
    if (wd_clear) begin
      st_nxt.wd_cnt = '0;
      st_nxt.wd_exp = 1'b0;
    end else if (st_r.tick && !st_r.wd_exp) begin
      if (st_r.wd_cnt == WW'(WDT_TICKS - 1)) begin
        st_nxt.wd_exp = 1'b1;
      end else begin
        st_nxt.wd_cnt = st_r.wd_cnt + 1'b1;
      end
    end

    // low supply forces the expired output
    st_nxt.wdo_n = ~(st_nxt.wd_exp | sup_low);
    st_nxt.pfo_n = pf_ok;
  end

  // State register; reset output is low from reset onward.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r.rst_state   <= RST_HOLD;
      st_r.stretch_cnt <= '0;
      st_r.pre_cnt     <= '0;
      st_r.tick        <= 1'b0;
      st_r.wd_cnt      <= '0;
      st_r.wd_exp      <= 1'b0;
      st_r.kick_prev   <= 1'b0;
      st_r.rst_n       <= 1'b0;
      st_r.wdo_n       <= 1'b1;
      st_r.pfo_n       <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign system_reset_n     = st_r.rst_n;
  assign system_reset       = ~st_r.rst_n;
  assign watchdog_expired_n = st_r.wdo_n;
  assign powerfail_flag_n   = st_r.pfo_n;

  // Checking aids: cycle counts since the last hold and the last clear.
  // Bounds assume one tick per millisecond; shorten only TB_CYCLES.
  localparam int unsigned RST_MIN_CYC = PULSE_MIN_MS * TB_CYCLES;
  localparam int unsigned RST_MAX_CYC = PULSE_MAX_MS * TB_CYCLES;
  localparam int unsigned WD_MIN_CYC  = WD_MIN_MS * TB_CYCLES;
  localparam int unsigned WD_MAX_CYC  = WD_MAX_MS * TB_CYCLES;

  logic [31:0] stretch_cyc_r;
  logic [31:0] wd_cyc_r;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stretch_cyc_r <= '0;
      wd_cyc_r      <= '0;
    end else begin
      if (st_r.rst_state == RST_HOLD) begin
        stretch_cyc_r <= '0;
      end else if (!st_r.rst_n) begin
        stretch_cyc_r <= stretch_cyc_r + 32'h1;
      end
      if (wd_clear) begin
        wd_cyc_r <= '0;
      end else if (!st_r.wd_exp) begin
        wd_cyc_r <= wd_cyc_r + 32'h1;
      end
    end
  end

  a_mr_starts_pulse :
    assert property (@(posedge clk_sys) disable iff (rst)
      mr_low |=> !system_reset_n ##1 !system_reset_n)
    else $error("manual reset low did not assert reset");

  a_stretch_span :
    assert property (@(posedge clk_sys) disable iff (rst)
      $rose(system_reset_n) |->
        (stretch_cyc_r >= RST_MIN_CYC) && (stretch_cyc_r <= RST_MAX_CYC))
    else $error("reset stretch outside its allowed span");

  a_supply_holds :
    assert property (@(posedge clk_sys) disable iff (rst)
      sup_low |=> !system_reset_n && (st_r.rst_state == RST_HOLD))
    else $error("reset released while supply is low");

  a_release_waits :
    assert property (@(posedge clk_sys) disable iff (rst)
      (st_r.rst_state == RST_HOLD) && !hold_req |=> !system_reset_n [*8])
    else $error("reset released early after hold ended");

  a_expiry_no_reset :
    assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st_r.wd_exp) && system_reset_n && !hold_req |=> system_reset_n)
    else $error("watchdog expiry asserted reset");

  a_wd_period_span :
    assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st_r.wd_exp) |->
        (wd_cyc_r >= WD_MIN_CYC) && (wd_cyc_r <= WD_MAX_CYC))
    else $error("watchdog period outside its allowed span");

  a_float_disables :
    assert property (@(posedge clk_sys) disable iff (rst)
      kick_hiz |=> (st_r.wd_cnt == '0) && !st_r.wd_exp)
    else $error("watchdog ran with a floating kick input");

  a_expired_holds :
    assert property (@(posedge clk_sys) disable iff (rst)
      st_r.wd_exp && !wd_clear |=> st_r.wd_exp && !watchdog_expired_n)
    else $error("expired output left low state without a clear");

  a_wdo_recovers :
    assert property (@(posedge clk_sys) disable iff (rst)
      $fell(sup_low) |=> watchdog_expired_n)
    else $error("expired output not released on supply recovery");

  a_pfo_follows :
    assert property (@(posedge clk_sys) disable iff (rst)
      ##1 powerfail_flag_n == $past(pf_ok))
    else $error("power-fail flag does not follow the comparator");

  a_reset_complement :
    assert property (@(posedge clk_sys) disable iff (rst)
      system_reset == !system_reset_n)
    else $error("active-high reset is not the complement");

  a_wd_counts :
    assert property (@(posedge clk_sys) disable iff (rst)
      !wd_clear && st_r.tick && !st_r.wd_exp &&
        (st_r.wd_cnt != WW'(WDT_TICKS - 1))
      |=> st_r.wd_cnt == $past(st_r.wd_cnt) + 1'b1)
    else $error("watchdog did not advance on a tick");

  a_kick_clears :
    assert property (@(posedge clk_sys) disable iff (rst)
      kick_edge |=> (st_r.wd_cnt == '0) && !st_r.wd_exp)
    else $error("kick edge did not clear the watchdog");

  a_reset_clears :
    assert property (@(posedge clk_sys) disable iff (rst)
      !system_reset_n |=> (st_r.wd_cnt == '0) && !st_r.wd_exp)
    else $error("watchdog not held clear during reset");

  a_expiry_drives_wdo :
    assert property (@(posedge clk_sys) disable iff (rst)
      $rose(st_r.wd_exp) |-> !watchdog_expired_n)
    else $error("expiry did not drive the expired output low");

  a_wdo_low_supply :
    assert property (@(posedge clk_sys) disable iff (rst)
      sup_low |=> !watchdog_expired_n)
    else $error("expired output high while supply is low");

  a_dip_restarts :
    assert property (@(posedge clk_sys) disable iff (rst)
      (st_r.rst_state == RST_STRETCH) && hold_req
      |=> (st_r.rst_state == RST_HOLD) && !system_reset_n)
    else $error("hold during the stretch did not restart it");

endmodule // ssw_supervisor

// File: core/ssw_pkg.sv
// Shared constants and types for the supply supervisor and watchdog.
package ssw_pkg;

  // Clock and internal timebase.
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned NS_PER_MS     = 1_000_000;
  localparam int unsigned TICK_TIME_NS  = 1_000_000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TICKS_PER_MS  = NS_PER_MS / TICK_TIME_NS;

  // Reset stretch, nominal value and limits, in milliseconds.
  localparam int unsigned PULSE_TIME_MS = 200;
  localparam int unsigned PULSE_MIN_MS  = 140;
  localparam int unsigned PULSE_MAX_MS  = 280;
  localparam int unsigned PULSE_TICKS   = PULSE_TIME_MS * TICKS_PER_MS;

  // Watchdog period, nominal value and limits, in milliseconds.
  localparam int unsigned WD_TIME_MS = 1600;
  localparam int unsigned WD_MIN_MS  = 1000;
  localparam int unsigned WD_MAX_MS  = 2250;
  localparam int unsigned WD_TICKS   = WD_TIME_MS * TICKS_PER_MS;

  // Shortest kick pulse the host may give, and its cycle count.
  localparam int unsigned KICK_PULSE_MIN_NS = 50;
  localparam int unsigned KICK_PULSE_CYCLES =
    (KICK_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Bit positions of the conditioned pin vector.
  localparam int unsigned PIN_MR    = 0;
  localparam int unsigned PIN_SUPLO = 1;
  localparam int unsigned PIN_PF    = 2;
  localparam int unsigned PIN_KICK  = 3;
  localparam int unsigned PIN_HIZ   = 4;
  localparam int unsigned PIN_COUNT = 5;

  // Pin levels assumed during reset: supply low, kick floating.
  localparam logic [PIN_COUNT-1:0] PIN_RESET = 5'h17;

  // Reset sequencer states.
  typedef enum logic [1:0] {
    RST_HOLD,
    RST_STRETCH,
    RST_RUN
  } ssw_rst_state_t;

endpackage

// File: core/ssw_pin_if.sv
// Carrier between the pin conditioner and the supervisor core.
interface ssw_pin_if #(
  parameter int unsigned W = 1
);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport cond (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// File: core/ssw_pin_filter.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
module ssw_pin_filter
  import ssw_pkg::*;
#(
  parameter int unsigned           W       = PIN_COUNT,
  parameter logic [PIN_COUNT-1:0]  RST_VAL = PIN_RESET
) (
  // Clock and reset.
  input wire logic  clk_sys,
  input wire logic  rst,
  // Raw pins in, filtered levels out.
  ssw_pin_if.cond   pins
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] clean;
  } ssw_filt_t;

  ssw_filt_t st_r;
  ssw_filt_t st_nxt;

  // A level is taken only once stages two and three agree, which
  // rejects a sample caught mid-transition; stage one feeds only two.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = pins.raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    for (int i = 0; i < W; i++) begin
      if (st_r.s2[i] == st_r.s3[i]) begin
        st_nxt.clean[i] = st_r.s3[i];
      end
    end
  end

  // State register.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= {4{RST_VAL[W-1:0]}};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pins.clean = st_r.clean;

endmodule // ssw_pin_filter

// File: tb/ssw_host_model.sv
// Host processor model that drives the watchdog kick pin.
module ssw_host_model (
  // Clock.
  input  wire logic clk_sys,
  // Requests from the bench.
  input  wire logic kick_go,
  input  wire logic float_en,
  // Kick pin and its undriven indication toward the device.
  output wire logic watchdog_kick_in,
  output wire logic watchdog_kick_hiz
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [1:0] pulse_r  = 2'h0;
  logic       wander_r = 1'b0;

  // kick pulse width
  // Each kick lasts three clocks, far over the shortest pulse and wider
  // than the two-clock agreement window of the pin filter.
  always @(posedge clk_sys) begin
    if (kick_go)
      pulse_r <= 2'h3;
    else if (pulse_r != 2'h0)
      pulse_r <= pulse_r - 2'h1;
    wander_r <= ~wander_r;
  end

  // A released pin holds no level, so it wanders every cycle on purpose.
  assign watchdog_kick_in  = float_en ? wander_r : (pulse_r != 2'h0);
  assign watchdog_kick_hiz = float_en;
endmodule // ssw_host_model

// File: tb/tb.sv
// Self-checking testbench for the supply supervisor and watchdog.
module tb
  import ssw_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int TBC = 4;
  localparam int LIM = (WD_TICKS + 100) * TBC;

  logic clk_sys            = 1'b0;
  logic rst                = 1'b1;
  logic supply_low_in      = 1'b1;
  logic powerfail_sense_in = 1'b1;
  logic manual_reset_n     = 1'b1;
  logic kick_go            = 1'b0;
  logic float_en           = 1'b1;
  logic pf;
  wire logic watchdog_kick_in;
  wire logic watchdog_kick_hiz;
  wire logic system_reset_n;
  wire logic system_reset;
  wire logic watchdog_expired_n;
  wire logic powerfail_flag_n;
  int   mismatches = 0;
  int   n_compared = 0;
  int   n;
  int   m;

  // The tick is shortened so the long counts run in a few thousand clocks.
  ssw_supervisor #(.TB_CYCLES(TBC)) u_dut (
    .clk_sys(clk_sys), .rst(rst), .supply_low_in(supply_low_in),
    .powerfail_sense_in(powerfail_sense_in),
    .manual_reset_n(manual_reset_n), .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_hiz(watchdog_kick_hiz), .system_reset_n(system_reset_n),
    .system_reset(system_reset), .watchdog_expired_n(watchdog_expired_n),
    .powerfail_flag_n(powerfail_flag_n));

  ssw_host_model u_host (
    .clk_sys(clk_sys), .kick_go(kick_go), .float_en(float_en),
    .watchdog_kick_in(watchdog_kick_in),
    .watchdog_kick_hiz(watchdog_kick_hiz));

  // Clock of 100 ns period.
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask

  task automatic kick();
    @(posedge clk_sys);
    kick_go <= 1'b1;
    @(posedge clk_sys);
    kick_go <= 1'b0;
  endtask

  task automatic check(input bit ok, input string msg);
    n_compared++;
    if (!ok) begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  function automatic logic sig(input int sel);
    return (sel == 0) ? system_reset_n : watchdog_expired_n;
  endfunction

  // Counts falling edges until the chosen output reaches a level.
  task automatic wait_for(input int sel, input logic lvl, input int lim,
                          output int cnt);
    cnt = 0;
    while (cnt < lim && sig(sel) !== lvl) begin
      @(negedge clk_sys);
      cnt++;
    end
  endtask

  // Window of a count of ticks, allowing a partial first tick and latency.
  function automatic bit win(input int ticks, input int cnt);
    return cnt >= (ticks - 1) * TBC && cnt <= ticks * TBC + 12;
  endfunction

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Both reset outputs must always be opposite.
  always @(negedge clk_sys) begin
    if (rst === 1'b0)
      check(system_reset === ~system_reset_n, "reset pair equal");
  end

  // Guard against a hang.
  initial begin
    #(80_000 * 100);
    mismatches++;
    $display("[FAIL] %0t run exceeded its time limit", $time);
    final_report();
  end

  initial begin
    void'($urandom(32'h1f97));
    cyc(4);
    rst <= 1'b0;
    // Power-up with supply low, then recovery and the stretch.
    cyc(20);
    check(system_reset_n === 1'b0, "reset not held in low supply");
    check(watchdog_expired_n === 1'b0, "flag not low in low supply");
    supply_low_in <= 1'b0;
    wait_for(1, 1'b1, 20, m);
    check(m <= 8, "flag slow to rise on recovery");
    check(system_reset_n === 1'b0, "reset not stretched");
    wait_for(0, 1'b1, LIM, n);
    check(win(PULSE_TICKS, m + n), "power-up stretch wrong");
    // A floating kick pin never lets the watchdog expire.
    wait_for(1, 1'b0, LIM, n);
    check(watchdog_expired_n === 1'b1, "expired while floating");
    // Driven kick pin held still: expiry, no reset, then clear by a kick.
    @(posedge clk_sys);
    float_en <= 1'b0;
    wait_for(1, 1'b0, LIM, n);
    check(win(WD_TICKS, n), "watchdog period wrong");
    check(system_reset_n === 1'b1, "expiry caused reset");
    cyc($urandom_range(40, 2));
    check(watchdog_expired_n === 1'b0, "expiry ended with no clear");
    kick();
    wait_for(1, 1'b1, 20, n);
    check(n <= 12, "kick did not clear expiry");
    // Kicks at 800 to 1590 ticks, inside the period, keep the watchdog quiet.
    repeat (5) begin
      wait_for(1, 1'b0, $urandom_range(1590, 800) * TBC, n);
      check(watchdog_expired_n === 1'b1, "expired despite kicks");
      kick();
    end
    // Manual reset, the second time with a supply dip in the stretch.
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      manual_reset_n <= 1'b0;
      wait_for(0, 1'b0, 20, n);
      check(n <= 8, "manual reset not taken");
      cyc($urandom_range(40, 3));
      check(watchdog_expired_n === 1'b1, "flag fell in manual reset");
      manual_reset_n <= 1'b1;
      if (i == 1) begin
        cyc(100 * TBC);
        supply_low_in <= 1'b1;
        cyc(10);
        supply_low_in <= 1'b0;
      end
      wait_for(0, 1'b1, 300 * TBC, n);
      if (i == 0)
        check(win(PULSE_TICKS, n), "manual stretch wrong");
      else
        check(n >= PULSE_MIN_MS * TBC && n <= PULSE_MAX_MS * TBC + 12,
              "dip did not extend pulse");
    end
    // The timer was cleared by reset and counts again from release.
    wait_for(1, 1'b0, LIM, n);
    check(win(WD_TICKS, n), "timer not cleared by reset");
    // Supply low while expired, then immediate rise on recovery.
    @(posedge clk_sys);
    supply_low_in <= 1'b1;
    cyc(20);
    check(watchdog_expired_n === 1'b0, "flag not low in low supply");
    check(system_reset_n === 1'b0, "reset not held in low supply");
    supply_low_in <= 1'b0;
    wait_for(1, 1'b1, 20, n);
    check(n <= 8, "flag delayed on recovery");
    // Power-fail flag follows the comparator, random levels.
    repeat (8) begin
      pf = 1'($urandom_range(1, 0));
      @(posedge clk_sys);
      powerfail_sense_in <= pf;
      cyc(6);
      check(powerfail_flag_n === pf, "power-fail flag wrong");
    end
    final_report();
  end
endmodule // tb
